// ---- verilog/ctm_pkg.sv ----
// Package for the CAN transceiver mode and wake control block.
// Assumes a single 25 MHz system clock; all times are converted to cycle counts here.
package ctm_pkg;

    // Clock period of the system time base.
    localparam int unsigned CLK_PERIOD_NS = 40;

    // Durations in nanoseconds and derived cycle counts.
    // Least times round up; the longest wake phase rounds down.
    localparam int unsigned ENABLE_DELAY_NS = 20000;
    localparam int unsigned ENABLE_DELAY_CYC = (ENABLE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WAKE_MIN_NS = 500;
    localparam int unsigned WAKE_MIN_CYC = (WAKE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WAKE_MAX_NS = 1800000;
    localparam int unsigned WAKE_MAX_CYC = WAKE_MAX_NS / CLK_PERIOD_NS;
    localparam int unsigned TX_DOM_LIMIT_NS = 2700000;
    localparam int unsigned TX_DOM_LIMIT_CYC = (TX_DOM_LIMIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned BUS_DOM_LIMIT_NS = 2700000;
    localparam int unsigned BUS_DOM_LIMIT_CYC =
        (BUS_DOM_LIMIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Width of every duration counter; all limits must stay below 2**17.
    localparam int unsigned CNT_W = 17;

    // Transceiver mode field codes.
    localparam logic [1:0] CAN_OFF = 2'h0;
    localparam logic [1:0] CAN_WAKE = 2'h1;
    localparam logic [1:0] CAN_RXONLY = 2'h2;
    localparam logic [1:0] CAN_NORMAL = 2'h3;
    localparam logic [1:0] CAN_MODE_RST = CAN_OFF;

    // System modes of the surrounding chip, one-hot.
    typedef enum logic [4:0] {
        SYS_NORMAL = 5'h01,
        SYS_STOP = 5'h02,
        SYS_SLEEP = 5'h04,
        SYS_RESTART = 5'h08,
        SYS_FAILSAFE = 5'h10
    } ctm_sys_e;
    localparam ctm_sys_e SYS_MODE_RST = SYS_NORMAL;

    // Wake pattern detector states, one-hot.
    typedef enum logic [3:0] {
        WK_IDLE = 4'h1,
        WK_DOM1 = 4'h2,
        WK_REC = 4'h4,
        WK_DOM2 = 4'h8
    } ctm_wk_e;

    // Host command strobes, each write field valid for one cycle.
    typedef struct packed {
        logic sys_wr;
        ctm_sys_e sys_mode;
        logic can_wr;
        logic [1:0] can_mode;
        logic wd_cfg_wr;
        logic wd_on_wake;
        logic wd_en;
        logic clr_flags;
    } ctm_cmd_s;

    // Status seen by the host.
    typedef struct packed {
        logic [1:0] can_mode;
        ctm_sys_e sys_mode;
        logic bus_wake_flag;
        logic wake_status;
        logic bus_fault_flag;
        logic supply_low_flag;
        logic tx_timeout;
        logic wd_en;
        logic tx_ready;
    } ctm_stat_s;

endpackage : ctm_pkg

// ---- verilog/ctm_can_mode_wake.sv ----
// CAN transceiver mode control, wake pattern detection and bus supervision.
// Assumes all inputs are synchronous to clk_sys_i and bus_dom_i is the receiver's
// digital view of the bus (high = dominant).
module ctm_can_mode_wake #(
    parameter int unsigned P_WAKE_MAX_CYC = ctm_pkg::WAKE_MAX_CYC,
    parameter int unsigned P_TX_DOM_LIMIT_CYC = ctm_pkg::TX_DOM_LIMIT_CYC,
    parameter int unsigned P_BUS_DOM_LIMIT_CYC = ctm_pkg::BUS_DOM_LIMIT_CYC
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire ctm_pkg::ctm_cmd_s cmd_i,
    input wire logic tx_data_in_i,
    input wire logic bus_dom_i,
    input wire logic supply_ok_i,
    output logic bus_drive_o,
    output logic rx_data_out_o,
    output logic irq_n_o,
    output ctm_pkg::ctm_stat_s status_o
);

    // Duration limits at counter width.
    localparam logic [ctm_pkg::CNT_W-1:0] EN_CYC =
        ctm_pkg::CNT_W'(ctm_pkg::ENABLE_DELAY_CYC);
    localparam logic [ctm_pkg::CNT_W-1:0] WMIN_CYC =
        ctm_pkg::CNT_W'(ctm_pkg::WAKE_MIN_CYC);
    localparam logic [ctm_pkg::CNT_W-1:0] WMAX_CYC = ctm_pkg::CNT_W'(P_WAKE_MAX_CYC);
    localparam logic [ctm_pkg::CNT_W-1:0] TXTO_CYC =
        ctm_pkg::CNT_W'(P_TX_DOM_LIMIT_CYC);
    localparam logic [ctm_pkg::CNT_W-1:0] BUSTO_CYC =
        ctm_pkg::CNT_W'(P_BUS_DOM_LIMIT_CYC);
    localparam logic [ctm_pkg::CNT_W-1:0] CNT_ONE = 17'h00001;
    localparam logic [ctm_pkg::CNT_W-1:0] CNT_ZERO = 17'h00000;

    logic [1:0] can_r, can_nxt;
    ctm_pkg::ctm_sys_e sys_r, sys_nxt;
    ctm_pkg::ctm_wk_e wk_r, wk_nxt;
    logic armed_r, armed_nxt;
    logic wflag_r, wflag_nxt;
    logic wstat_r, wstat_nxt;
    logic irq_r, irq_nxt;
    logic fault_r, fault_nxt;
    logic uv_r, uv_nxt;
    logic wd_en_r, wd_en_nxt;
    logic wd_on_r, wd_on_nxt;
    logic [ctm_pkg::CNT_W-1:0] ph_r, ph_nxt;
    logic [ctm_pkg::CNT_W-1:0] en_r, en_nxt;
    logic [ctm_pkg::CNT_W-1:0] txc_r, txc_nxt;
    logic [ctm_pkg::CNT_W-1:0] busc_r, busc_nxt;
    logic blk_r, blk_nxt;
    logic to_r, to_nxt;
    logic drive_r, drive_nxt;
    logic rx_r, rx_nxt;
    logic en_done;
    logic rx_active;
    logic wake_hit;
    logic can_ok;

    assign en_done = (en_r >= EN_CYC);
    assign rx_active = (can_r == ctm_pkg::CAN_NORMAL) || (can_r == ctm_pkg::CAN_RXONLY);

    // Mode, wake and flag control. Flag sets are applied after the clears so a
    // hardware event in the same cycle as a host clear is never lost.
    always_comb begin
        can_nxt = can_r;
        sys_nxt = sys_r;
        armed_nxt = armed_r;
        wflag_nxt = wflag_r;
        wstat_nxt = wstat_r;
        irq_nxt = irq_r;
        fault_nxt = fault_r;
        uv_nxt = uv_r;
        wd_en_nxt = wd_en_r;
        wd_on_nxt = wd_on_r;
        wk_nxt = wk_r;
        ph_nxt = ph_r;
        wake_hit = 1'b0;
        can_ok = 1'b0;

        // Host clears; clearing the wake flag makes the transceiver wake capable again.
        if (cmd_i.clr_flags) begin
            wstat_nxt = 1'b0;
            irq_nxt = 1'b0;
            fault_nxt = 1'b0;
            uv_nxt = 1'b0;
            wflag_nxt = 1'b0;
            armed_nxt = 1'b1;
        end
        if (cmd_i.wd_cfg_wr) begin
            wd_on_nxt = cmd_i.wd_on_wake;
            wd_en_nxt = cmd_i.wd_en;
        end

        // System mode commands; undefined codes are ignored.
        if (cmd_i.sys_wr) begin
            case (cmd_i.sys_mode)
                ctm_pkg::SYS_NORMAL, ctm_pkg::SYS_SLEEP, ctm_pkg::SYS_RESTART: begin
                    sys_nxt = cmd_i.sys_mode;
                end
                ctm_pkg::SYS_STOP: begin
                    sys_nxt = ctm_pkg::SYS_STOP;
                    armed_nxt = 1'b1;
                    wflag_nxt = 1'b0;
                end
                ctm_pkg::SYS_FAILSAFE: begin
                    sys_nxt = ctm_pkg::SYS_FAILSAFE;
                    can_nxt = ctm_pkg::CAN_WAKE;
                    armed_nxt = 1'b1;
                    wflag_nxt = 1'b0;
                end
                default: begin
                    sys_nxt = sys_r;
                end
            endcase
        end

        // Transceiver mode commands; all but off are gated by the current system mode.
        if (cmd_i.can_wr) begin
            case (cmd_i.can_mode)
                ctm_pkg::CAN_OFF: can_ok = 1'b1;
                ctm_pkg::CAN_NORMAL: can_ok = (sys_r == ctm_pkg::SYS_NORMAL);
                ctm_pkg::CAN_RXONLY: begin
                    can_ok = (sys_r == ctm_pkg::SYS_NORMAL) || (sys_r == ctm_pkg::SYS_STOP);
                end
                ctm_pkg::CAN_WAKE: can_ok = (sys_r != ctm_pkg::SYS_FAILSAFE);
                default: can_ok = 1'b0;
            endcase
            if (can_ok) begin
                can_nxt = cmd_i.can_mode;
                if (cmd_i.can_mode != ctm_pkg::CAN_WAKE) begin
                    wflag_nxt = 1'b0;
                end else if (can_r != ctm_pkg::CAN_WAKE) begin
                    armed_nxt = 1'b1;
                    wflag_nxt = 1'b0;
                end
            end
        end

        // Wake pattern detector: each phase counted in ph_r, saturating at the maximum
        // so that an over-long phase can never qualify when it ends.
        if ((can_r != ctm_pkg::CAN_WAKE) || !armed_r) begin
            wk_nxt = ctm_pkg::WK_IDLE;
            ph_nxt = CNT_ZERO;
        end else begin
            case (wk_r)
                ctm_pkg::WK_IDLE: begin
                    if (bus_dom_i) begin
                        wk_nxt = ctm_pkg::WK_DOM1;
                        ph_nxt = CNT_ONE;
                    end
                end
                ctm_pkg::WK_DOM1: begin
                    if (bus_dom_i) begin
                        ph_nxt = (ph_r >= WMAX_CYC) ? ph_r : ph_r + CNT_ONE;
                    end else if ((ph_r > WMIN_CYC) && (ph_r < WMAX_CYC)) begin
                        wk_nxt = ctm_pkg::WK_REC;
                        ph_nxt = CNT_ONE;
                    end else begin
                        wk_nxt = ctm_pkg::WK_IDLE;
                    end
                end
                ctm_pkg::WK_REC: begin
                    if (!bus_dom_i) begin
                        ph_nxt = (ph_r >= WMAX_CYC) ? ph_r : ph_r + CNT_ONE;
                    end else if ((ph_r > WMIN_CYC) && (ph_r < WMAX_CYC)) begin
                        wk_nxt = ctm_pkg::WK_DOM2;
                        ph_nxt = CNT_ONE;
                    end else begin
                        wk_nxt = ctm_pkg::WK_DOM1; // A bad gap restarts the pattern here.
                        ph_nxt = CNT_ONE;
                    end
                end
                ctm_pkg::WK_DOM2: begin
                    if (bus_dom_i) begin
                        ph_nxt = (ph_r >= WMAX_CYC) ? ph_r : ph_r + CNT_ONE;
                    end else begin
                        wake_hit = (ph_r > WMIN_CYC) && (ph_r < WMAX_CYC);
                        wk_nxt = ctm_pkg::WK_IDLE;
                    end
                end
                default: begin
                    wk_nxt = ctm_pkg::WK_IDLE;
                    ph_nxt = CNT_ZERO;
                end
            endcase
        end

        // Wake event actions depend on the system mode at detection.
        if (wake_hit) begin
            wflag_nxt = 1'b1;
            armed_nxt = 1'b0;
            wstat_nxt = 1'b1;
            case (sys_r)
                ctm_pkg::SYS_NORMAL: irq_nxt = 1'b1;
                ctm_pkg::SYS_STOP: begin
                    irq_nxt = 1'b1;
                    if (wd_on_r && !wd_en_r) begin
                        wd_en_nxt = 1'b1;
                    end
                end
                ctm_pkg::SYS_SLEEP, ctm_pkg::SYS_FAILSAFE: begin
                    sys_nxt = ctm_pkg::SYS_RESTART;
                end
                default: sys_nxt = sys_r; // Restart stays in restart.
            endcase
        end

        // Supervision flags; the condition re-sets the flag while it persists.
        if (to_nxt) begin
            fault_nxt = 1'b1;
        end
        if (rx_active && bus_dom_i && (busc_r >= BUSTO_CYC)) begin
            fault_nxt = 1'b1;
        end
        if (rx_active && !supply_ok_i) begin
            uv_nxt = 1'b1;
        end
    end

    // Transmit path: enable delay, early-low blocking, stuck-dominant time-out and
    // bus clamp timer. The time-out counters saturate one step past their limits; the enable counter stops at its limit.
    always_comb begin
        en_nxt = en_r;
        blk_nxt = blk_r;
        txc_nxt = txc_r;
        to_nxt = to_r;
        busc_nxt = busc_r;
        drive_nxt = 1'b0;
        rx_nxt = 1'b1;

        if (can_r != ctm_pkg::CAN_NORMAL) begin
            en_nxt = CNT_ZERO;
            blk_nxt = 1'b0;
        end else begin
            if (!en_done) begin
                en_nxt = en_r + CNT_ONE;
            end
            // Any high sample ends the block, so a low that was returned high in time
            // lets the first fresh dominant bit after the delay through.
            if (tx_data_in_i) begin
                blk_nxt = 1'b0;
            end else if (!en_done) begin
                blk_nxt = 1'b1;
            end
        end

        if ((can_r == ctm_pkg::CAN_NORMAL) && !tx_data_in_i) begin
            txc_nxt = (txc_r > TXTO_CYC) ? txc_r : txc_r + CNT_ONE;
            to_nxt = to_r || (txc_r >= TXTO_CYC);
        end else begin
            txc_nxt = CNT_ZERO;
            to_nxt = 1'b0;
        end

        if (rx_active && bus_dom_i) begin
            busc_nxt = (busc_r > BUSTO_CYC) ? busc_r : busc_r + CNT_ONE;
        end else begin
            busc_nxt = CNT_ZERO;
        end

        // Driver enable; off, wake and receive-only never drive the bus.
        drive_nxt = (can_r == ctm_pkg::CAN_NORMAL) && en_done && !blk_nxt && !to_nxt
            && supply_ok_i && !tx_data_in_i;

        // Receive output per mode.
        case (can_r)
            ctm_pkg::CAN_NORMAL, ctm_pkg::CAN_RXONLY: rx_nxt = !bus_dom_i;
            ctm_pkg::CAN_WAKE: rx_nxt = !wflag_r;
            default: rx_nxt = 1'b1;
        endcase
    end

    // State registers; the mode bits are touched only by commands and wake events.
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            can_r <= ctm_pkg::CAN_MODE_RST;
            sys_r <= ctm_pkg::SYS_MODE_RST;
            wk_r <= ctm_pkg::WK_IDLE;
            armed_r <= 1'b1;
            wflag_r <= 1'b0;
            wstat_r <= 1'b0;
            irq_r <= 1'b0;
            fault_r <= 1'b0;
            uv_r <= 1'b0;
            wd_en_r <= 1'b0;
            wd_on_r <= 1'b0;
            ph_r <= 17'h00000;
            en_r <= 17'h00000;
            txc_r <= 17'h00000;
            busc_r <= 17'h00000;
            blk_r <= 1'b0;
            to_r <= 1'b0;
            drive_r <= 1'b0;
            rx_r <= 1'b1;
        end else begin
            can_r <= can_nxt;
            sys_r <= sys_nxt;
            wk_r <= wk_nxt;
            armed_r <= armed_nxt;
            wflag_r <= wflag_nxt;
            wstat_r <= wstat_nxt;
            irq_r <= irq_nxt;
            fault_r <= fault_nxt;
            uv_r <= uv_nxt;
            wd_en_r <= wd_en_nxt;
            wd_on_r <= wd_on_nxt;
            ph_r <= ph_nxt;
            en_r <= en_nxt;
            txc_r <= txc_nxt;
            busc_r <= busc_nxt;
            blk_r <= blk_nxt;
            to_r <= to_nxt;
            drive_r <= drive_nxt;
            rx_r <= rx_nxt;
        end
    end

    // Outputs come straight from flip-flops, except tx_ready, which is decoded from en_r, and irq_n_o, which inverts irq_r.
    assign bus_drive_o = drive_r;
    assign rx_data_out_o = rx_r;
    assign irq_n_o = !irq_r;
    assign status_o.can_mode = can_r;
    assign status_o.sys_mode = sys_r;
    assign status_o.bus_wake_flag = wflag_r;
    assign status_o.wake_status = wstat_r;
    assign status_o.bus_fault_flag = fault_r;
    assign status_o.supply_low_flag = uv_r;
    assign status_o.tx_timeout = to_r;
    assign status_o.wd_en = wd_en_r;
    assign status_o.tx_ready = en_done;

endmodule // ctm_can_mode_wake

// ---- verification/ctm_bus_node.sv ----
// Bus side model: remote nodes sharing one wired bus with the block's driver.
// Assumes the bench pulses wake_go_i for one cycle and holds clamp_i as a level.
module ctm_bus_node (
    input wire logic clk_sys_i,
    input wire logic bus_drive_i,
    input wire logic wake_go_i,
    input wire logic [7:0] phase_len_i,
    input wire logic clamp_i,
    output logic bus_dom_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    logic remote_dom = 1'b0;
    // Dominant wins on the wire, so a stuck remote node also clamps the bus.
    assign bus_dom_o = bus_drive_i | remote_dom | clamp_i;
    // Remote wake sender: dominant, recessive, dominant, one phase length each.
    always @(posedge clk_sys_i) begin
        if (wake_go_i) begin
            cnt <= 1;
        end else if (cnt != 0) begin
            cnt <= (cnt >= 3 * phase_len_i) ? 0 : cnt + 1;
        end
        remote_dom <= wake_go_i || (cnt != 0 && cnt < phase_len_i) ||
            (cnt >= 2 * phase_len_i && cnt < 3 * phase_len_i);
    end
endmodule // ctm_bus_node

// ---- verification/ctm_can_mode_wake_assertions.sv ----
// Concurrent checks on the ports of the mode and wake control block.
// Assumes one clock domain with a synchronous active-low reset.
module ctm_can_mode_wake_chk #(
    parameter int unsigned P_TX_DOM_LIMIT_CYC = ctm_pkg::TX_DOM_LIMIT_CYC
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire ctm_pkg::ctm_cmd_s cmd_i,
    input wire logic tx_data_in_i,
    input wire logic bus_dom_i,
    input wire logic supply_ok_i,
    input wire logic bus_drive_o,
    input wire logic rx_data_out_o,
    input wire logic irq_n_o,
    input wire ctm_pkg::ctm_stat_s status_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    logic [17:0] low_cnt_r;
    logic [17:0] low_cnt_nxt;
    // Counts low transmit samples in normal mode; saturates so it never wraps.
    always_comb begin
        low_cnt_nxt = '0;
        if (!tx_data_in_i && status_o.can_mode == ctm_pkg::CAN_NORMAL) begin
            low_cnt_nxt = (low_cnt_r == '1) ? low_cnt_r : low_cnt_r + 18'h1;
        end
    end
    // Registers the helper count.
    always_ff @(posedge clk_sys_i) begin
        low_cnt_r <= resetn_i ? low_cnt_nxt : '0;
    end
    chk_off_rx_high: assert property (
        status_o.can_mode == ctm_pkg::CAN_OFF |=> rx_data_out_o)
        else $error("receive output low while off");
    chk_normal_legal: assert property (
        status_o.can_mode == ctm_pkg::CAN_NORMAL && $past(status_o.can_mode) != ctm_pkg::CAN_NORMAL
        |-> $past(status_o.sys_mode) == ctm_pkg::SYS_NORMAL)
        else $error("normal mode entered outside normal system mode");
    chk_tx_follows: assert property (
        bus_drive_o |-> !$past(tx_data_in_i) && $past(status_o.can_mode) == ctm_pkg::CAN_NORMAL)
        else $error("driver dominant without a low transmit input");
    chk_ready_gate: assert property (
        !status_o.tx_ready |=> !bus_drive_o)
        else $error("driver active before enable delay");
    chk_rx_follows: assert property (
        $past(status_o.can_mode) == ctm_pkg::CAN_NORMAL |-> rx_data_out_o == !$past(bus_dom_i))
        else $error("receive output does not follow bus");
    chk_nonnormal_quiet: assert property (
        status_o.can_mode != ctm_pkg::CAN_NORMAL ##1 status_o.can_mode != ctm_pkg::CAN_NORMAL
        |-> !bus_drive_o)
        else $error("driver active outside normal mode");
    chk_wake_rx_low: assert property (
        status_o.can_mode == ctm_pkg::CAN_WAKE && status_o.bus_wake_flag |=> !rx_data_out_o)
        else $error("receive output not low after wake");
    chk_sleep_no_irq: assert property (
        status_o.sys_mode == ctm_pkg::SYS_SLEEP && irq_n_o && !status_o.bus_wake_flag
        ##1 status_o.bus_wake_flag |-> irq_n_o)
        else $error("interrupt raised on wake from sleep");
    chk_stuck_fault: assert property (
        low_cnt_r > P_TX_DOM_LIMIT_CYC + 2
        |-> status_o.tx_timeout && status_o.bus_fault_flag && !bus_drive_o)
        else $error("stuck transmit input not cut off");
    chk_timeout_release: assert property (
        tx_data_in_i |=> !status_o.tx_timeout)
        else $error("transmit time-out not released");
endmodule // ctm_can_mode_wake_chk

bind ctm_can_mode_wake ctm_can_mode_wake_chk #(
    .P_TX_DOM_LIMIT_CYC(P_TX_DOM_LIMIT_CYC)
) u_chk (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .cmd_i(cmd_i),
    .tx_data_in_i(tx_data_in_i), .bus_dom_i(bus_dom_i), .supply_ok_i(supply_ok_i),
    .bus_drive_o(bus_drive_o), .rx_data_out_o(rx_data_out_o), .irq_n_o(irq_n_o),
    .status_o(status_o));

// ---- verification/tb_top.sv ----
// Self-checking bench for the mode and wake control block with a bus model.
// Assumes the checker is bound to the block and the package is compiled first.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {int due; int id; logic [7:0] v;} ctm_note_s;
    logic clk_sys_i = 0, resetn_i = 0, tx_data_in_i = 1, supply_ok_i = 1;
    logic wake_go = 0, clamp = 0, bus_dom_i, bus_drive_o, rx_data_out_o, irq_n_o;
    logic [7:0] phase_len = 8'h14;
    logic [31:0] r;
    ctm_pkg::ctm_cmd_s cmd_i = '0;
    ctm_pkg::ctm_stat_s status_o;
    int err_count = 0, cmp_count = 0, cyc = 0, seed = 32'hd091;
    ctm_note_s notes[$];
    string names[11] = '{"drive", "rx", "irq_n", "can_mode", "sys_mode", "fault", "wake_flag",
        "tx_ready", "wd_en", "supply_low", "wake_stat"};
    // Short limits keep the time-out runs brief.
    ctm_can_mode_wake #(.P_WAKE_MAX_CYC(40), .P_TX_DOM_LIMIT_CYC(30), .P_BUS_DOM_LIMIT_CYC(30))
        DUT (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .cmd_i(cmd_i),
        .tx_data_in_i(tx_data_in_i), .bus_dom_i(bus_dom_i), .supply_ok_i(supply_ok_i),
        .bus_drive_o(bus_drive_o), .rx_data_out_o(rx_data_out_o), .irq_n_o(irq_n_o),
        .status_o(status_o));
    ctm_bus_node u_bus (.clk_sys_i(clk_sys_i), .bus_drive_i(bus_drive_o), .wake_go_i(wake_go),
        .phase_len_i(phase_len), .clamp_i(clamp), .bus_dom_o(bus_dom_i));
    // Free-running 25 MHz clock and a cycle count for timing the notes.
    initial forever #20 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) cyc <= cyc + 1;
    function automatic logic [7:0] pick(int id);
        case (id)
            0: return {7'h0, bus_drive_o};
            1: return {7'h0, rx_data_out_o};
            2: return {7'h0, irq_n_o};
            3: return {6'h0, status_o.can_mode};
            4: return {3'h0, status_o.sys_mode};
            5: return {7'h0, status_o.bus_fault_flag};
            6: return {7'h0, status_o.bus_wake_flag};
            7: return {7'h0, status_o.tx_ready};
            8: return {7'h0, status_o.wd_en};
            9: return {7'h0, status_o.supply_low_flag};
            default: return {7'h0, status_o.wake_status};
        endcase
    endfunction
    task automatic check(string what, logic [7:0] exp, logic [7:0] seen);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        if (err_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Notes fall due at the falling edge, when outputs have settled.
    always @(negedge clk_sys_i) begin
        while (notes.size() > 0 && notes[0].due <= cyc) begin
            check(names[notes[0].id], notes[0].v, pick(notes[0].id));
            void'(notes.pop_front());
        end
    end
    task automatic note(int id, logic [7:0] v, int d);
        notes.push_back('{cyc + d, id, v});
    endtask
    task automatic step(int n);
        repeat (n) @(posedge clk_sys_i);
        #2;
    endtask
    task automatic can(logic [1:0] m);
        cmd_i.can_wr = 1;
        cmd_i.can_mode = m;
        step(1);
        cmd_i.can_wr = 0;
    endtask
    task automatic sys(ctm_pkg::ctm_sys_e m);
        cmd_i.sys_wr = 1;
        cmd_i.sys_mode = m;
        step(1);
        cmd_i.sys_wr = 0;
    endtask
    task automatic wake(int wait_n);
        wake_go = 1;
        step(1);
        wake_go = 0;
        step(wait_n);
    endtask
    // Bounded wait; running out of cycles counts as a mismatch and ends the run.
    task automatic wait_for(int id, logic [7:0] v, int max);
        int k = 0;
        while (pick(id) !== v && k < max) begin
            step(1);
            k++;
        end
        if (k >= max) begin
            err_count++;
            final_report();
        end
    endtask
    initial begin
        step(6);
        resetn_i = 1;
        note(3, 8'h0, 0);
        note(1, 8'h1, 0);
        wake(70);
        note(6, 8'h0, 0);
        sys(ctm_pkg::SYS_STOP);
        can(ctm_pkg::CAN_NORMAL);
        note(3, 8'h0, 0);
        sys(ctm_pkg::SYS_NORMAL);
        can(ctm_pkg::CAN_NORMAL);
        note(7, 8'h0, 0);
        tx_data_in_i = 0;
        step(10);
        note(0, 8'h0, 0);
        tx_data_in_i = 1;
        wait_for(7, 8'h1, 600);
        // Random transmit bits; the bus is looped back through the model.
        for (int i = 0; i < 40; i++) begin
            note(1, {7'h0, tx_data_in_i}, 1);
            r = $random(seed);
            tx_data_in_i = r[0];
            note(0, {7'h0, !r[0]}, 1);
            step(1);
        end
        tx_data_in_i = 0;
        step(34);
        note(5, 8'h1, 0);
        note(0, 8'h0, 0);
        note(3, 8'h3, 0);
        tx_data_in_i = 1;
        step(1);
        tx_data_in_i = 0;
        note(0, 8'h1, 1);
        step(1);
        // Supply drop while still transmitting: driver cut, flag set, mode kept.
        supply_ok_i = 0;
        note(0, 8'h0, 1);
        note(9, 8'h1, 1);
        note(3, 8'h3, 1);
        step(1);
        supply_ok_i = 1;
        note(0, 8'h1, 1);
        step(1);
        tx_data_in_i = 1;
        cmd_i.clr_flags = 1;
        can(ctm_pkg::CAN_RXONLY);
        cmd_i.clr_flags = 0;
        note(5, 8'h0, 0);
        note(9, 8'h0, 0);
        clamp = 1;
        tx_data_in_i = 0;
        step(35);
        note(5, 8'h1, 0);
        note(3, 8'h2, 0);
        note(0, 8'h0, 0);
        clamp = 0;
        tx_data_in_i = 1;
        step(2);
        can(ctm_pkg::CAN_WAKE);
        phase_len = 8'h08;
        wake(40);
        note(6, 8'h0, 0);
        phase_len = 8'h14;
        wake(0);
        wait_for(6, 8'h1, 100);
        note(2, 8'h0, 0);
        note(3, 8'h1, 0);
        note(1, 8'h0, 1);
        step(2);
        can(ctm_pkg::CAN_NORMAL);
        note(6, 8'h0, 0);
        step(1);
        can(ctm_pkg::CAN_WAKE);
        wake(0);
        wait_for(6, 8'h1, 100);
        cmd_i.wd_cfg_wr = 1;
        cmd_i.wd_on_wake = 1;
        cmd_i.wd_en = 0;
        sys(ctm_pkg::SYS_STOP);
        cmd_i.wd_cfg_wr = 0;
        note(6, 8'h0, 0);
        wake(0);
        wait_for(6, 8'h1, 100);
        note(8, 8'h1, 0);
        note(4, {3'h0, ctm_pkg::SYS_STOP}, 0);
        cmd_i.clr_flags = 1;
        sys(ctm_pkg::SYS_SLEEP);
        cmd_i.clr_flags = 0;
        wake(0);
        wait_for(6, 8'h1, 100);
        note(4, {3'h0, ctm_pkg::SYS_RESTART}, 0);
        note(2, 8'h1, 0);
        note(10, 8'h1, 0);
        note(1, 8'h0, 1);
        step(3);
        // Fail-safe entry forces wake-capable mode and rearms the detector.
        can(ctm_pkg::CAN_OFF);
        note(1, 8'h1, 1);
        sys(ctm_pkg::SYS_FAILSAFE);
        note(3, 8'h1, 0);
        note(6, 8'h0, 0);
        wake(0);
        wait_for(6, 8'h1, 100);
        note(4, {3'h0, ctm_pkg::SYS_RESTART}, 0);
        step(2);
        final_report();
    end
endmodule // tb_top
